// [hw/cw_decoder_pkg.sv]
// shared constants, state type and register map of the control word decoder
package cw_decoder_pkg;
  localparam logic [7:0]  ADDR_CTRL_WORD   = 8'h00;
  localparam logic [7:0]  ADDR_REFERENCE   = 8'h04;
  localparam logic [7:0]  ADDR_CONFIG      = 8'h08;
  localparam logic [7:0]  ADDR_QSTOP_TIME  = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS      = 8'h10;
  localparam logic [7:0]  ADDR_INTERNAL    = 8'h14;
  localparam logic [2:0]  PROFILE_CONVERT  = 3'h0;
  localparam logic [2:0]  PROFILE_PASS     = 3'h5;
  localparam int          CFG_PROFILE_LSB  = 0;
  localparam int          CFG_RUN_SRC      = 4;
  localparam int          CFG_RAMP_IN_SRC  = 5;
  localparam int          CFG_RESET_SRC    = 6;
  localparam int          CFG_JOG_SRC      = 7;
  localparam int          CFG_LOC_SRC      = 8;
  localparam logic [31:0] CONFIG_RESET     = 32'h000001F0;
  localparam logic [15:0] QSTOP_TIME_RESET = 16'h03E8;
  localparam int          CW_RAMP_STOP_N   = 0;
  localparam int          CW_COAST_STOP_N  = 1;
  localparam int          CW_QUICK_STOP_N  = 2;
  localparam int          CW_ENABLE_OP     = 3;
  localparam int          CW_RAMP_OUT_N    = 4;
  localparam int          CW_RAMP_HOLD_N   = 5;
  localparam int          CW_RAMP_IN_N     = 6;
  localparam int          CW_FAULT_RESET   = 7;
  localparam int          CW_JOG_ONE       = 8;
  localparam int          CW_JOG_TWO       = 9;
  localparam int          CW_FB_CONTROL    = 10;
  localparam int          CW_LOCATION      = 11;
  localparam int          CW_USER_LSB      = 12;
  localparam int          CLK_HZ           = 50_000_000;
  localparam int          MS_PER_S         = 1000;
  localparam int          MS_CYCLES        = CLK_HZ / MS_PER_S;
  typedef enum logic [3:0] {
    switch_on_blocked, ready_switch_on, ready_operate, op_inhibited, op_enabled,
    ramp_stop_active, coast_stop_active, quick_stop_active, fault_state
  } drive_state_e;
endpackage

// [hw/cw_regs_if.sv]
// register carrier between the bus slave and the decoder core
`timescale 1ns/1ns
interface cw_regs_if;
  logic        cw_strobe;
  logic [31:0] control_word;
  logic [31:0] reference;
  logic [31:0] config_word;
  logic [15:0] qstop_ms;
  logic [31:0] status;
  logic [31:0] internal_word;
  modport regs (output cw_strobe, control_word, reference, config_word, qstop_ms,
                input status, internal_word);
  modport core (input cw_strobe, control_word, reference, config_word, qstop_ms,
                output status, internal_word);
endinterface

// [hw/cw_apb_regs.sv]
// apb slave holding the control word, reference and configuration
`timescale 1ns/1ns
module cw_apb_regs
  import cw_decoder_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // core side
  cw_regs_if.regs          rif
);
  logic mapped;
  logic wr_ok;

  assign mapped = paddr inside {ADDR_CTRL_WORD, ADDR_REFERENCE, ADDR_CONFIG,
                                ADDR_QSTOP_TIME, ADDR_STATUS, ADDR_INTERNAL};
  // a frozen block must not complete transfers it cannot act on
  assign pready  = ce;
  assign pslverr = psel & penable & ~mapped;
  assign wr_ok   = ce & psel & penable & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rif.control_word <= 32'h00000000;
      rif.reference    <= 32'h00000000;
      rif.config_word  <= CONFIG_RESET;
      rif.qstop_ms     <= QSTOP_TIME_RESET;
      rif.cw_strobe    <= 1'b0;
    end else if (ce) begin
      rif.cw_strobe <= 1'b0;
      if (wr_ok && paddr == ADDR_CTRL_WORD) begin
        rif.control_word <= pwdata;
        rif.cw_strobe    <= 1'b1;
      end
      if (wr_ok && paddr == ADDR_REFERENCE) rif.reference <= pwdata;
      if (wr_ok && paddr == ADDR_QSTOP_TIME) rif.qstop_ms <= pwdata[15:0];
      if (wr_ok && paddr == ADDR_CONFIG) begin
        if (pwdata[CFG_PROFILE_LSB +: 3] inside {PROFILE_CONVERT, PROFILE_PASS})
          rif.config_word <= pwdata;
        else
          rif.config_word <= {pwdata[31:3], rif.config_word[2:0]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce && psel && !penable) begin
      case (paddr)
        ADDR_CTRL_WORD:  prdata <= rif.control_word;
        ADDR_REFERENCE:  prdata <= rif.reference;
        ADDR_CONFIG:     prdata <= rif.config_word;
        ADDR_QSTOP_TIME: prdata <= {16'h0000, rif.qstop_ms};
        ADDR_STATUS:     prdata <= rif.status;
        ADDR_INTERNAL:   prdata <= rif.internal_word;
        default:         prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// [hw/cw_stop_timer.sv]
// millisecond countdown bounding the quick stop
`timescale 1ns/1ns
module cw_stop_timer #(
  parameter int MS_CYCLES = 50000
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // control
  input  wire logic        start,
  input  wire logic        clear,
  input  wire logic [15:0] time_ms,
  output logic             expired
);
  localparam int PW = $clog2(MS_CYCLES + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYCLES - 1);
  logic [PW-1:0] pre;
  logic [15:0]   ms_left;
  logic          running;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre     <= '0;
      ms_left <= 16'h0000;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (ce) begin
      // start beats clear: it arrives while the state is not yet quick stop
      if (start) begin
        pre     <= '0;
        ms_left <= time_ms;
        running <= 1'b1;
        expired <= 1'b0;
      end else if (clear) begin
        running <= 1'b0;
        expired <= 1'b0;
      end else if (running && pre == PRE_LAST) begin
        pre <= '0;
        if (ms_left == 16'h0000) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          ms_left <= ms_left - 16'h0001;
        end
      end else if (running) begin
        pre <= pre + PW'(1);
      end
    end
  end
endmodule

// [hw/fieldbus_control_word_decoder.sv]
// control word decoder: apb registers, word latch, request decode, drive state
`timescale 1ns/1ns
module fieldbus_control_word_decoder
  import cw_decoder_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // drive feedback
  input  wire logic        fault_active,
  input  wire logic        motor_stopped,
  input  wire logic        run_enable_in,
  input  wire logic        local_location_two,
  // drive state
  output logic      [3:0]  state_code,
  output logic             operation_on,
  output logic             ramp_stop_active_o,
  output logic             coast_stop_active_o,
  output logic             quick_stop_active_o,
  output logic             switch_on_blocked_o,
  // ramp generator requests
  output logic             ramp_out_zero,
  output logic             ramp_hold,
  output logic             ramp_in_zero,
  output logic             ramp_lock,
  // other requests
  output logic             run_enable,
  output logic             fault_clear,
  output logic             jog_one,
  output logic             jog_two,
  output logic             location_select,
  output logic      [3:0]  user_bits,
  // converted words
  output logic             pass_through_profile,
  output logic      [31:0] internal_word,
  output logic      [31:0] reference_out
);
  cw_regs_if rif ();

  drive_state_e state;
  drive_state_e next_state;
  logic [31:0]  eff_cw;
  logic         prev_reset_bit;
  logic         reset_edge;
  logic         qs_start;
  logic         qs_expired;
  logic         fb_run;
  logic         fb_ramp_in;
  logic         fb_reset;
  logic         fb_jog;
  logic         fb_loc;
  logic         in_pass;
  logic         run_en_now;
  logic [31:0]  new_cw;

  cw_apb_regs u_regs (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rif     (rif)
  );

  cw_stop_timer #(
    .MS_CYCLES (MS_CYCLES_P)
  ) u_qs_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .start   (qs_start),
    .clear   (state != quick_stop_active),
    .time_ms (rif.qstop_ms),
    .expired (qs_expired)
  );

  assign new_cw     = rif.control_word;
  assign fb_run     = rif.config_word[CFG_RUN_SRC];
  assign fb_ramp_in = rif.config_word[CFG_RAMP_IN_SRC];
  assign fb_reset   = rif.config_word[CFG_RESET_SRC];
  assign fb_jog     = rif.config_word[CFG_JOG_SRC];
  assign fb_loc     = rif.config_word[CFG_LOC_SRC];
  assign in_pass    = rif.config_word[CFG_PROFILE_LSB +: 3] == PROFILE_PASS;
  assign run_en_now = fb_run ? eff_cw[CW_ENABLE_OP] : run_enable_in;

  // word latch: each new word is judged once, when it arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eff_cw         <= 32'h00000000;
      reference_out  <= 32'h00000000;
      ramp_lock      <= 1'b1;
      prev_reset_bit <= 1'b0;
      reset_edge     <= 1'b0;
    end else if (ce) begin
      reset_edge <= 1'b0;
      if (rif.cw_strobe && !in_pass) begin
        prev_reset_bit <= new_cw[CW_FAULT_RESET];
        if (new_cw[CW_FB_CONTROL]) begin
          eff_cw        <= new_cw;
          reference_out <= rif.reference;
          ramp_lock     <= 1'b0;
          reset_edge    <= fb_reset & new_cw[CW_FAULT_RESET] & ~prev_reset_bit;
        end else if (new_cw == 32'h00000000 && rif.reference == 32'h00000000) begin
          ramp_lock <= 1'b1;
        end
      end else if (rif.cw_strobe) begin
        reference_out <= rif.reference;
      end
    end
  end

  // internal word: native packing or raw copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_word        <= 32'h00000000;
      pass_through_profile <= 1'b0;
    end else if (ce) begin
      pass_through_profile <= in_pass;
      if (in_pass) begin
        if (rif.cw_strobe) internal_word <= {16'h0000, new_cw[15:0]};
      end else begin
        internal_word <= {15'h0000, ramp_lock, user_bits, run_enable, location_select,
                          jog_two, jog_one, fault_clear, ramp_in_zero, ramp_hold,
                          ramp_out_zero, quick_stop_active_o, coast_stop_active_o,
                          ramp_stop_active_o, operation_on};
      end
    end
  end

  // ramp generator and auxiliary requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_out_zero   <= 1'b1;
      ramp_hold       <= 1'b1;
      ramp_in_zero    <= 1'b1;
      run_enable      <= 1'b0;
      jog_one         <= 1'b0;
      jog_two         <= 1'b0;
      location_select <= 1'b0;
      user_bits       <= 4'h0;
    end else if (ce) begin
      ramp_out_zero   <= ~eff_cw[CW_RAMP_OUT_N] | ramp_lock;
      ramp_hold       <= ~eff_cw[CW_RAMP_HOLD_N] | ramp_lock;
      ramp_in_zero    <= fb_ramp_in & ~eff_cw[CW_RAMP_IN_N];
      run_enable      <= run_en_now;
      jog_one         <= fb_jog & eff_cw[CW_JOG_ONE];
      jog_two         <= fb_jog & eff_cw[CW_JOG_TWO];
      location_select <= fb_loc ? eff_cw[CW_LOCATION] : local_location_two;
      user_bits       <= eff_cw[CW_USER_LSB +: 4];
    end
  end

  // fault clear is a one-cycle request to the drive's fault logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_clear <= 1'b0;
    end else if (ce) begin
      fault_clear <= reset_edge & (state == fault_state);
    end
  end

  // stop interlocks take priority over the run sequence
  always_comb begin
    next_state = state;
    qs_start   = 1'b0;
    case (state)
      switch_on_blocked: begin
        if (!eff_cw[CW_RAMP_STOP_N] && eff_cw[CW_COAST_STOP_N] && eff_cw[CW_QUICK_STOP_N])
          next_state = ready_switch_on;
      end
      ready_switch_on: begin
        if (eff_cw[CW_RAMP_STOP_N])
          next_state = ready_operate;
      end
      ready_operate, op_inhibited: begin
        if (eff_cw[CW_ENABLE_OP] && run_en_now)
          next_state = op_enabled;
        else if (!eff_cw[CW_RAMP_STOP_N])
          next_state = ready_switch_on;
      end
      op_enabled: begin
        if (!eff_cw[CW_RAMP_STOP_N])
          next_state = ramp_stop_active;
        else if (!eff_cw[CW_ENABLE_OP] || !run_en_now)
          next_state = op_inhibited;
      end
      ramp_stop_active: begin
        if (motor_stopped)
          next_state = ready_switch_on;
      end
      coast_stop_active: begin
        if (motor_stopped)
          next_state = switch_on_blocked;
      end
      quick_stop_active: begin
        if (motor_stopped || qs_expired)
          next_state = switch_on_blocked;
      end
      fault_state: begin
        if (reset_edge && !fault_active)
          next_state = switch_on_blocked;
      end
      default: next_state = switch_on_blocked;
    endcase
    if (state != fault_state && state != switch_on_blocked) begin
      if (!eff_cw[CW_COAST_STOP_N]) begin
        next_state = (state == coast_stop_active) ? next_state : coast_stop_active;
      end else if (!eff_cw[CW_QUICK_STOP_N] && state != quick_stop_active
                   && state != coast_stop_active) begin
        next_state = (state == op_enabled || state == ramp_stop_active) ?
                     quick_stop_active : switch_on_blocked;
        qs_start   = next_state == quick_stop_active;
      end
    end
    if (fault_active && state != fault_state)
      next_state = fault_state;
    if (next_state != quick_stop_active)
      qs_start = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= switch_on_blocked;
    else if (ce)  state <= next_state;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_code          <= 4'h0;
      operation_on        <= 1'b0;
      ramp_stop_active_o  <= 1'b0;
      coast_stop_active_o <= 1'b0;
      quick_stop_active_o <= 1'b0;
      switch_on_blocked_o <= 1'b1;
    end else if (ce) begin
      state_code          <= 4'(next_state);
      operation_on        <= next_state == op_enabled;
      ramp_stop_active_o  <= next_state == ramp_stop_active;
      coast_stop_active_o <= next_state == coast_stop_active;
      quick_stop_active_o <= next_state == quick_stop_active;
      switch_on_blocked_o <= next_state == switch_on_blocked;
    end
  end

  // readable state for software
  assign rif.status = {15'h0000, in_pass, fault_active, ramp_lock, eff_cw[CW_FB_CONTROL],
                       run_en_now, quick_stop_active_o, coast_stop_active_o,
                       ramp_stop_active_o, switch_on_blocked_o, operation_on,
                       fault_clear, 2'b00, state_code};
  assign rif.internal_word = internal_word;
endmodule

// [verif/cw_decoder_properties.sv]
// port assertions for the control word decoder
`timescale 1ns/1ns
module cw_decoder_properties
  import cw_decoder_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // drive side
  input wire logic        fault_active,
  input wire logic [3:0]  state_code,
  input wire logic        operation_on,
  input wire logic        ramp_stop_active_o,
  input wire logic        coast_stop_active_o,
  input wire logic        quick_stop_active_o,
  input wire logic        switch_on_blocked_o,
  input wire logic        ramp_out_zero,
  input wire logic        fault_clear,
  input wire logic [3:0]  user_bits,
  input wire logic        pass_through_profile
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = paddr inside {ADDR_CTRL_WORD, ADDR_REFERENCE, ADDR_CONFIG,
                                ADDR_QSTOP_TIME, ADDR_STATUS, ADDR_INTERNAL};
  sequence access_s;
    psel && penable && ce;
  endsequence
  // only words that take control, decoded by the converting profile
  sequence cw_write_s;
    access_s ##0 pwrite && paddr == ADDR_CTRL_WORD && pwdata[CW_FB_CONTROL]
      && !pass_through_profile;
  endsequence
  a_ready_follows_ce: assert property (pready == ce)
    else $error("pready differs from ce");
  a_unmapped_error: assert property (access_s |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_unmapped_read: assert property (access_s ##0 !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_blocked_flag: assert property (switch_on_blocked_o == (state_code == 4'h0))
    else $error("blocked flag and state disagree");
  a_operation_flag: assert property (operation_on == (state_code == 4'h4))
    else $error("operation flag and state disagree");
  a_ramp_stop_flag: assert property (ramp_stop_active_o == (state_code == 4'h5))
    else $error("ramp stop flag and state disagree");
  a_coast_flag: assert property (coast_stop_active_o == (state_code == 4'h6))
    else $error("coast flag and state disagree");
  a_quick_flag: assert property (quick_stop_active_o == (state_code == 4'h7))
    else $error("quick stop flag and state disagree");
  a_clear_pulse: assert property (fault_clear |=> !fault_clear)
    else $error("fault clear longer than one cycle");
  a_fault_entry: assert property (fault_active |=> state_code == 4'h8)
    else $error("fault not entered");
  a_user_follow: assert property (cw_write_s |-> ##3 user_bits == $past(pwdata[15:12], 3))
    else $error("user bits not taken from word");
  a_ramp_out_follow: assert property (cw_write_s |-> ##3 ramp_out_zero == !$past(pwdata[4], 3))
    else $error("ramp output request wrong");
endmodule
bind fieldbus_control_word_decoder cw_decoder_properties #(.MS_CYCLES_P(MS_CYCLES_P)) props (
  .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .fault_active, .state_code, .operation_on, .ramp_stop_active_o, .coast_stop_active_o,
  .quick_stop_active_o, .switch_on_blocked_o, .ramp_out_zero, .fault_clear, .user_bits,
  .pass_through_profile);

// [verif/fieldbus_master_model.sv]
// fieldbus master model writing control words over apb
`timescale 1ns/1ns
module fieldbus_master_model
  import cw_decoder_pkg::*;
(
  // clock
  input  wire logic        pclk,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  output logic             hang
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hFF;
    pwdata = 32'h0;
    hang = 1'b0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) hang <= 1'b1;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep a stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    xfer(1'b1, a, d, rd);
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [31:0] rd);
    xfer(1'b0, a, 32'h0, rd);
  endtask
  task automatic send_word(input logic [15:0] w);
    write_reg(ADDR_CTRL_WORD, {16'h0000, w});
  endtask
endmodule

// [verif/tb.sv]
// self-checking bench for the control word decoder
`timescale 1ns/1ns
module tb;
  import cw_decoder_pkg::*;
  localparam int MSC = 10;
  logic pclk, presetn, ce, fault_active, motor_stopped, run_enable_in, local_location_two;
  logic psel, penable, pwrite, pready, pslverr, hang;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, internal_word, reference_out;
  logic [3:0]  state_code, user_bits, spin;
  logic operation_on, ramp_stop_active_o, coast_stop_active_o, quick_stop_active_o;
  logic switch_on_blocked_o, ramp_out_zero, ramp_hold, ramp_in_zero, ramp_lock, run_enable;
  logic fault_clear, jog_one, jog_two, location_select, pass_through_profile, shaft_hold;
  int num_errors, n_tests, pulses, base;
  fieldbus_control_word_decoder #(.MS_CYCLES_P(MSC)) uut (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .fault_active, .motor_stopped, .run_enable_in, .local_location_two,
    .state_code, .operation_on, .ramp_stop_active_o, .coast_stop_active_o,
    .quick_stop_active_o, .switch_on_blocked_o, .ramp_out_zero, .ramp_hold, .ramp_in_zero,
    .ramp_lock, .run_enable, .fault_clear, .jog_one, .jog_two, .location_select,
    .user_bits, .pass_through_profile, .internal_word, .reference_out);
  fieldbus_master_model m (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                           .pready, .hang);
  always #10 pclk = ~pclk;
  // plant: shaft comes to rest a few cycles after operation ends
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spin <= 4'h0;
      motor_stopped <= 1'b1;
      pulses <= 0;
    end else begin
      spin <= {spin[2:0], operation_on === 1'b1};
      motor_stopped <= (spin == 4'h0) && !shaft_hold;
      if (fault_clear === 1'b1) pulses <= pulses + 1;
    end
  end
  always @(posedge hang) begin
    num_errors++;
    final_report();
  end
  task automatic final_report();
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic wait_state(input logic [3:0] s);
    int n;
    n = 0;
    while (state_code !== s && n < 200) begin
      tick(1);
      n++;
    end
    check("state_code", s, state_code);
    if (n >= 200) final_report();
  endtask
  task automatic run_up();
    m.send_word(16'h0406);
    wait_state(4'h1);
    m.send_word(16'h0407);
    wait_state(4'h2);
    m.send_word(16'h047F);
    wait_state(4'h4);
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    fault_active = 1'b0;
    shaft_hold = 1'b0;
    run_enable_in = 1'b0;
    local_location_two = 1'b0;
    num_errors = 0;
    n_tests = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check("reset_flags", 6'h3E, {switch_on_blocked_o, ramp_out_zero, ramp_hold, ramp_in_zero, ramp_lock, operation_on});
    m.read_reg(ADDR_CONFIG, rd);
    check("config", CONFIG_RESET, rd);
    m.read_reg(ADDR_QSTOP_TIME, rd);
    check("qstop", {16'h0, QSTOP_TIME_RESET}, rd);
    m.read_reg(8'h20, rd);
    check("unmapped", 32'h0, rd);
    run_up();
    check("run_enable", 1'b1, run_enable);
    for (int k = 4; k < 7; k++) begin
      m.send_word(16'h047F & ~(16'h1 << k));
      tick(3);
      check("ramp_req", {1'b0, k == 6, k == 5, k == 4}, {ramp_lock, ramp_in_zero, ramp_hold, ramp_out_zero});
    end
    m.send_word(16'hAF7F);
    tick(3);
    check("jog_loc_user", 7'h7A, {jog_one, jog_two, location_select, user_bits});
    m.write_reg(ADDR_REFERENCE, 32'h0000_1234);
    m.send_word(16'h047F);
    tick(3);
    check("jog_loc_user", 7'h00, {jog_one, jog_two, location_select, user_bits});
    check("reference", 32'h0000_1234, reference_out);
    check("native", 32'h0000_0801, internal_word);
    m.send_word(16'h0010);
    tick(6);
    check("retain", 6'h04, {ramp_hold, ramp_lock, state_code});
    m.write_reg(ADDR_REFERENCE, 32'h0);
    m.send_word(16'h0000);
    tick(3);
    check("lock", 3'h7, {ramp_lock, ramp_out_zero, ramp_hold});
    m.send_word(16'h047E);
    wait_state(4'h5);
    wait_state(4'h1);
    run_up();
    m.send_word(16'h047D);
    wait_state(4'h6);
    wait_state(4'h0);
    m.write_reg(ADDR_QSTOP_TIME, 32'h2);
    run_up();
    // shaft kept turning so only the stop timer can end the quick stop
    shaft_hold <= 1'b1;
    m.send_word(16'h047B);
    wait_state(4'h7);
    tick(10);
    check("quick_hold", 1'b1, quick_stop_active_o);
    wait_state(4'h0);
    shaft_hold <= 1'b0;
    @(posedge pclk);
    fault_active <= 1'b1;
    wait_state(4'h8);
    @(posedge pclk);
    fault_active <= 1'b0;
    base = pulses;
    m.send_word(16'h04FF);
    tick(6);
    check("clear_pulses", 1, pulses - base);
    wait_state(4'h0);
    @(posedge pclk);
    fault_active <= 1'b1;
    wait_state(4'h8);
    @(posedge pclk);
    fault_active <= 1'b0;
    base = pulses;
    m.send_word(16'h04FF);
    tick(6);
    check("steady_high", 0, pulses - base);
    check("fault_kept", 4'h8, state_code);
    m.send_word(16'h047F);
    m.send_word(16'h04FF);
    wait_state(4'h0);
    m.write_reg(ADDR_CONFIG, 32'h1F5);
    m.send_word(16'h5A3C);
    tick(3);
    check("pass_word", 32'h0000_5A3C, internal_word);
    check("pass_frozen", 5'h10, {pass_through_profile, user_bits});
    m.write_reg(ADDR_CONFIG, 32'h1F3);
    m.read_reg(ADDR_INTERNAL, rd);
    check("internal_reg", 32'h0000_5A3C, rd);
    check("bad_profile", 1'b1, pass_through_profile);
    m.write_reg(ADDR_CONFIG, 32'h0E0);
    @(posedge pclk);
    local_location_two <= 1'b1;
    m.send_word(16'h04FE);
    tick(3);
    check("local_src", 3'h2, {pass_through_profile, location_select, run_enable});
    @(posedge pclk);
    ce <= 1'b0;
    run_enable_in <= 1'b1;
    tick(4);
    check("frozen_run", 1'b0, run_enable);
    @(posedge pclk);
    ce <= 1'b1;
    tick(3);
    check("local_run", 1'b1, run_enable);
    final_report();
  end
endmodule
